/* hdl/dso_bank.sv */
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "dso_regs.svh"
// Behaviour
// RQ1: Reading a signal field returns the live raw level of its signal.
// RQ2: With the global force set, written field values feed the debounce.
// RQ3: With the global force clear, raw signals feed the debounce unchanged.
// RQ4: The loop-lock force bit 9 forces the lock indication high when 1.
// RQ5: The debounce tick force bit 8 swaps every tick for the 16 kHz tick.
// RQ6: The alarm force bit 6 drives the alarm signal to 1 when set.
// RQ7: The power state machine clears the regulator fields to 0.
module dso_bank
    import dso_pkg::*;
(
    input wire logic ref_clk, // 20 MHz clock
    input wire logic rst_n, // Synchronous reset
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [15:0] raw_supply, // Raw supply comparators
    input wire logic [15:0] raw_regulator, // Raw regulator status
    input wire logic [15:0] raw_charger, // Raw charger comparators
    input wire logic raw_loop_lock, // Raw freq_lock_loop lock
    input wire logic raw_alarm, // Raw clock alarm
    input wire logic tick_normal, // Normal debounce tick
    input wire logic tick_16k, // 16 kHz debounce tick
    input wire logic sm_clear, // Power state machine clear
    output logic [15:0] deb_supply, // Supply levels to debounce
    output logic [15:0] deb_regulator, // Regulator levels to debounce
    output logic [15:0] deb_charger, // Charger levels to debounce
    output logic lock_ind, // Lock indication
    output logic alarm_out, // Clock alarm signal
    output logic deb_tick // Tick to debounce block
);
    // =================================================================
    // Input synchronisers
    logic [15:0] sup_meta, sup_sync;
    logic [15:0] reg_meta, reg_sync;
    logic [15:0] chg_meta, chg_sync;
    logic [1:0] misc_meta, misc_sync;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sup_meta <= `DSO_RESET_FIELD;
            sup_sync <= `DSO_RESET_FIELD;
            reg_meta <= `DSO_RESET_FIELD;
            reg_sync <= `DSO_RESET_FIELD;
            chg_meta <= `DSO_RESET_FIELD;
            chg_sync <= `DSO_RESET_FIELD;
            misc_meta <= 2'h0;
            misc_sync <= 2'h0;
        end
        else
        begin
            sup_meta <= raw_supply;
            sup_sync <= sup_meta;
            reg_meta <= raw_regulator;
            reg_sync <= reg_meta;
            chg_meta <= raw_charger;
            chg_sync <= chg_meta;
            misc_meta <= {raw_alarm, raw_loop_lock};
            misc_sync <= misc_meta;
        end
    end

    // =================================================================
    // Write channel and register storage
    dso_wr_state_t wr_state, next_wr_state;
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [11:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic [1:0] bresp, next_bresp;
    dso_field_t sup_field, next_sup_field;
    dso_field_t reg_field, next_reg_field;
    dso_field_t chg_field, next_chg_field;
    logic global_analogue_force, next_global_analogue_force;
    dso_field_t wr_val;

    assign s_axi_awready = (wr_state == DSO_WR_IDLE) && !aw_held;
    assign s_axi_wready = (wr_state == DSO_WR_IDLE) && !w_held;
    assign s_axi_bvalid = (wr_state == DSO_WR_RESP);
    assign s_axi_bresp = bresp;

    always_comb
    begin
        next_wr_state = wr_state;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bresp = bresp;
        next_sup_field = sup_field;
        next_reg_field = reg_field;
        next_chg_field = chg_field;
        next_global_analogue_force = global_analogue_force;
        wr_val = `DSO_RESET_FIELD;
        case (wr_state)
            DSO_WR_IDLE:
            begin
                if (s_axi_awvalid && s_axi_awready)
                begin
                    next_aw_held = 1'b1;
                    next_aw_addr = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready)
                begin
                    next_w_held = 1'b1;
                    next_w_data = s_axi_wdata;
                    next_w_strb = s_axi_wstrb;
                end
                if (aw_held && w_held)
                begin
                    next_aw_held = 1'b0;
                    next_w_held = 1'b0;
                    next_wr_state = DSO_WR_RESP;
                    next_bresp = `DSO_RESP_OKAY;
                    if (aw_addr == `DSO_ADDR_SUPPLY)
                    begin
                        wr_val = sup_field;
                    end
                    else if (aw_addr == `DSO_ADDR_REGULATOR)
                    begin
                        wr_val = reg_field;
                    end
                    else if (aw_addr == `DSO_ADDR_CHARGER)
                    begin
                        wr_val = chg_field;
                    end
                    if (w_strb[0])
                    begin
                        wr_val[7:0] = w_data[7:0];
                    end
                    if (w_strb[1])
                    begin
                        wr_val[15:8] = w_data[15:8];
                    end
                    if (aw_addr == `DSO_ADDR_SUPPLY)
                    begin
                        next_sup_field = wr_val & (`DSO_MASK_SUPPLY
                            | `DSO_MASK_SUPPLY_CTRL);
                    end
                    else if (aw_addr == `DSO_ADDR_REGULATOR)
                    begin
                        next_reg_field = wr_val & `DSO_MASK_REGULATOR;
                    end
                    else if (aw_addr == `DSO_ADDR_CHARGER)
                    begin
                        next_chg_field = wr_val & `DSO_MASK_CHARGER;
                    end
                    else if (aw_addr == `DSO_ADDR_GLOBAL)
                    begin
                        if (w_strb[0])
                        begin
                            next_global_analogue_force =
                                w_data[`DSO_BIT_GLOBAL];
                        end
                    end
                    else
                    begin
                        next_bresp = `DSO_RESP_SLVERR;
                    end
                end
            end
            DSO_WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    next_wr_state = DSO_WR_IDLE;
                end
            end
            default:
            begin
                next_wr_state = DSO_WR_IDLE;
            end
        endcase
        if (sm_clear)
        begin
            next_reg_field = `DSO_RESET_FIELD; // RQ7
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wr_state <= DSO_WR_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bresp <= `DSO_RESP_OKAY;
            sup_field <= `DSO_RESET_FIELD;
            reg_field <= `DSO_RESET_FIELD;
            chg_field <= `DSO_RESET_FIELD;
            global_analogue_force <= 1'b0;
        end
        else
        begin
            wr_state <= next_wr_state;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bresp <= next_bresp;
            sup_field <= next_sup_field;
            reg_field <= next_reg_field;
            chg_field <= next_chg_field;
            global_analogue_force <= next_global_analogue_force;
        end
    end

    // =================================================================
    // Read channel
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;

    assign s_axi_arready = !rvalid;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

    always_comb
    begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
        else if (s_axi_arvalid && !rvalid)
        begin
            next_rvalid = 1'b1;
            next_rresp = `DSO_RESP_OKAY;
            next_rdata = 32'h0000_0000;
            if (s_axi_araddr == `DSO_ADDR_SUPPLY)
            begin
                next_rdata[15:0] = (sup_sync & `DSO_MASK_SUPPLY)
                    | (sup_field & `DSO_MASK_SUPPLY_CTRL); // RQ1
            end
            else if (s_axi_araddr == `DSO_ADDR_REGULATOR)
            begin
                next_rdata[15:0] = reg_sync & `DSO_MASK_REGULATOR; // RQ1
            end
            else if (s_axi_araddr == `DSO_ADDR_CHARGER)
            begin
                next_rdata[15:0] = chg_sync & `DSO_MASK_CHARGER; // RQ1
            end
            else if (s_axi_araddr == `DSO_ADDR_GLOBAL)
            begin
                next_rdata[`DSO_BIT_GLOBAL] = global_analogue_force;
            end
            else
            begin
                next_rresp = `DSO_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `DSO_RESP_OKAY;
        end
        else
        begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // =================================================================
    // Debounce input selection
    dso_field_t next_deb_supply, next_deb_regulator, next_deb_charger;
    logic next_lock_ind, next_alarm_out, next_deb_tick;
    logic loop_lock_force, debounce_tick_force, alarm_force;

    assign loop_lock_force = sup_field[`DSO_BIT_LOOP_LOCK];
    assign debounce_tick_force = sup_field[`DSO_BIT_DEB_TICK];
    assign alarm_force = sup_field[`DSO_BIT_ALARM];

    always_comb
    begin
        if (global_analogue_force)
        begin
            next_deb_supply = sup_field & `DSO_MASK_SUPPLY; // RQ2
            next_deb_regulator = reg_field & `DSO_MASK_REGULATOR; // RQ2
            next_deb_charger = chg_field & `DSO_MASK_CHARGER; // RQ2
        end
        else
        begin
            next_deb_supply = sup_sync & `DSO_MASK_SUPPLY; // RQ3
            next_deb_regulator = reg_sync & `DSO_MASK_REGULATOR; // RQ3
            next_deb_charger = chg_sync & `DSO_MASK_CHARGER; // RQ3
        end
        next_lock_ind = misc_sync[0] | loop_lock_force; // RQ4
        next_alarm_out = misc_sync[1] | alarm_force; // RQ6
        next_deb_tick = debounce_tick_force ? tick_16k : tick_normal; // RQ5
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            deb_supply <= `DSO_RESET_FIELD;
            deb_regulator <= `DSO_RESET_FIELD;
            deb_charger <= `DSO_RESET_FIELD;
            lock_ind <= 1'b0;
            alarm_out <= 1'b0;
            deb_tick <= 1'b0;
        end
        else
        begin
            deb_supply <= next_deb_supply;
            deb_regulator <= next_deb_regulator;
            deb_charger <= next_deb_charger;
            lock_ind <= next_lock_ind;
            alarm_out <= next_alarm_out;
            deb_tick <= next_deb_tick;
        end
    end

    // =================================================================
    // Checks
    sequence regulator_read_s;
        s_axi_arvalid && s_axi_arready
            && s_axi_araddr == `DSO_ADDR_REGULATOR;
    endsequence

    chk_raw_readback: assert property ( // RQ1
        @(posedge ref_clk) disable iff (!rst_n)
        regulator_read_s |=> s_axi_rvalid
            && s_axi_rdata[15:0] == ($past(reg_sync) & `DSO_MASK_REGULATOR))
        else $error("regulator read does not show raw level");

    chk_forced_path: assert property ( // RQ2
        @(posedge ref_clk) disable iff (!rst_n)
        global_analogue_force |=>
            deb_charger == ($past(chg_field) & `DSO_MASK_CHARGER))
        else $error("forced charger value not passed");

    chk_raw_path: assert property ( // RQ3
        @(posedge ref_clk) disable iff (!rst_n)
        !global_analogue_force |=>
            deb_supply == ($past(sup_sync) & `DSO_MASK_SUPPLY))
        else $error("raw supply value not passed");

    chk_lock_force: assert property ( // RQ4
        @(posedge ref_clk) disable iff (!rst_n)
        loop_lock_force || misc_sync[0] |=> lock_ind)
        else $error("lock indication not asserted");

    chk_tick_force: assert property ( // RQ5
        @(posedge ref_clk) disable iff (!rst_n)
        debounce_tick_force |=> deb_tick == $past(tick_16k))
        else $error("debounce tick not taken from 16 kHz tick");

    chk_alarm_force: assert property ( // RQ6
        @(posedge ref_clk) disable iff (!rst_n)
        alarm_force |=> alarm_out)
        else $error("alarm not forced high");

    sequence clear_s;
        sm_clear ##1 global_analogue_force;
    endsequence

    chk_state_clear: assert property ( // RQ7
        @(posedge ref_clk) disable iff (!rst_n)
        clear_s |=> deb_regulator == `DSO_RESET_FIELD)
        else $error("regulator fields not cleared");

    chk_write_answer: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        aw_held && w_held |=> s_axi_bvalid)
        else $error("write response late");
endmodule

/* hdl/dso_pkg.sv */
package dso_pkg;
    typedef enum logic [1:0] {
        DSO_WR_IDLE = 2'b01,
        DSO_WR_RESP = 2'b10
    } dso_wr_state_t;
    typedef logic [15:0] dso_field_t;
endpackage

/* hdl/dso_regs.svh */
`ifndef DSO_REGS_SVH
`define DSO_REGS_SVH
// =====================================================================
// Register indices and byte addresses
`define DSO_IDX_SUPPLY 10'h0E0
`define DSO_IDX_REGULATOR 10'h0E1
`define DSO_IDX_CHARGER 10'h0E2
`define DSO_IDX_GLOBAL 10'h0F0
`define DSO_ADDR_SUPPLY {`DSO_IDX_SUPPLY, 2'h0}
`define DSO_ADDR_REGULATOR {`DSO_IDX_REGULATOR, 2'h0}
`define DSO_ADDR_CHARGER {`DSO_IDX_CHARGER, 2'h0}
`define DSO_ADDR_GLOBAL {`DSO_IDX_GLOBAL, 2'h0}
// =====================================================================
// Field layout
`define DSO_MASK_SUPPLY 16'h0C8F
`define DSO_MASK_SUPPLY_CTRL 16'h0340
`define DSO_MASK_REGULATOR 16'h8F3F
`define DSO_MASK_CHARGER 16'hC807
`define DSO_BIT_LOOP_LOCK 9
`define DSO_BIT_DEB_TICK 8
`define DSO_BIT_ALARM 6
`define DSO_BIT_GLOBAL 0
`define DSO_RESET_FIELD 16'h0000
// =====================================================================
// Bus answers
`define DSO_RESP_OKAY 2'h0
`define DSO_RESP_SLVERR 2'h2
`endif

/* tb/debounce_signal_override_bank_tb.sv */
`timescale 1ns/10ps
`include "dso_regs.svh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin fails++; \
$display("Error %s expected %h seen %h", n, e, a); end end
module debounce_signal_override_bank_tb
    import dso_pkg::*;
;
    localparam dso_field_t MS = `DSO_MASK_SUPPLY;
    localparam dso_field_t MR = `DSO_MASK_REGULATOR;
    localparam dso_field_t MC = `DSO_MASK_CHARGER;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, sm_clear = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tk;
    logic [1:0] bresp, rresp, e2;
    logic [33:0] e34;
    dso_field_t lvl_s = 16'h0, lvl_r = 16'h0, lvl_c = 16'h0, w;
    logic lvl_lock = 1'b0, lvl_alarm = 1'b0;
    dso_field_t raw_s, raw_r, raw_c, deb_s, deb_r, deb_c;
    logic raw_lock, raw_alarm, t_norm, t_16k, lock_ind, alarm_out, deb_tick;
    int fails = 0, total_checks = 0;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    always #25 ref_clk = ~ref_clk;
    dso_bank u_dso_bank (.ref_clk(ref_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .raw_supply(raw_s),
        .raw_regulator(raw_r), .raw_charger(raw_c), .raw_loop_lock(raw_lock),
        .raw_alarm(raw_alarm), .tick_normal(t_norm), .tick_16k(t_16k),
        .sm_clear(sm_clear), .deb_supply(deb_s), .deb_regulator(deb_r),
        .deb_charger(deb_c), .lock_ind(lock_ind), .alarm_out(alarm_out),
        .deb_tick(deb_tick));
    dso_src_model u_dso_src_model (.ref_clk(ref_clk), .lvl_supply(lvl_s),
        .lvl_regulator(lvl_r), .lvl_charger(lvl_c), .lvl_lock(lvl_lock),
        .lvl_alarm(lvl_alarm), .raw_supply(raw_s), .raw_regulator(raw_r),
        .raw_charger(raw_c), .raw_loop_lock(raw_lock),
        .raw_alarm(raw_alarm), .tick_normal(t_norm), .tick_16k(t_16k));
    // =================================================================
    // Bus master
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] e);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge ref_clk);
        bq.push_back(e);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge ref_clk);
            if (awvalid && awready === 1'b1)
            begin
                ad = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready === 1'b1)
            begin
                wd = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        do @(posedge ref_clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
        @(posedge ref_clk);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(posedge ref_clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask
    // =================================================================
    // Result watcher
    always @(posedge ref_clk)
    begin
        if (bvalid === 1'b1 && bready)
        begin
            e2 = bq.pop_front();
            `CHK("bresp", e2, bresp)
        end
        if (rvalid === 1'b1 && rready)
        begin
            e34 = rq.pop_front();
            `CHK("rdata_rresp", e34, {rdata, rresp})
        end
    end
    task automatic cmp_deb(input dso_field_t s, r, c);
        `CHK("deb_supply", s, deb_s)
        `CHK("deb_regulator", r, deb_r)
        `CHK("deb_charger", c, deb_c)
    endtask
    task automatic conclude();
        $display("Checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        conclude();
    end
    // =================================================================
    // Tests
    initial
    begin
        w = 16'($urandom(32'hc9719805));
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        axi_rd(`DSO_ADDR_GLOBAL, {32'h0, `DSO_RESP_OKAY});
        cmp_deb(16'h0, 16'h0, 16'h0);
        $display("Test reset done");
        for (int i = 0; i < 4; i++)
        begin
            lvl_s <= 16'($urandom());
            lvl_r <= 16'($urandom());
            lvl_c <= 16'($urandom());
            w = 16'($urandom());
            axi_wr(`DSO_ADDR_REGULATOR, {16'h0, w}, 4'hF, `DSO_RESP_OKAY);
            axi_wr(`DSO_ADDR_CHARGER, {16'h0, ~w}, 4'hF, `DSO_RESP_OKAY);
            repeat (2) @(posedge ref_clk);
            axi_rd(`DSO_ADDR_SUPPLY, {16'h0, lvl_s & MS, 2'h0});
            axi_rd(`DSO_ADDR_REGULATOR, {16'h0, lvl_r & MR, 2'h0});
            axi_rd(`DSO_ADDR_CHARGER, {16'h0, lvl_c & MC, 2'h0});
            cmp_deb(lvl_s & MS, lvl_r & MR, lvl_c & MC);
        end
        $display("Test readback done");
        axi_wr(`DSO_ADDR_GLOBAL, 32'h1, 4'hF, `DSO_RESP_OKAY);
        w = 16'($urandom());
        axi_wr(`DSO_ADDR_SUPPLY, {16'h0, w & MS}, 4'hF, `DSO_RESP_OKAY);
        axi_wr(`DSO_ADDR_REGULATOR, {16'h0, ~w}, 4'hF, `DSO_RESP_OKAY);
        axi_wr(`DSO_ADDR_CHARGER, {16'h0, w ^ 16'h5A5A}, 4'hF, 2'h0);
        lvl_s <= ~lvl_s;
        lvl_r <= ~lvl_r;
        lvl_c <= ~lvl_c;
        repeat (4) @(posedge ref_clk);
        cmp_deb(w & MS, ~w & MR, (w ^ 16'h5A5A) & MC);
        axi_rd(`DSO_ADDR_SUPPLY, {16'h0, lvl_s & MS, 2'h0});
        axi_wr(`DSO_ADDR_GLOBAL, 32'h0, 4'hF, `DSO_RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        cmp_deb(lvl_s & MS, lvl_r & MR, lvl_c & MC);
        $display("Test global force done");
        axi_wr(`DSO_ADDR_SUPPLY, 32'h0240, 4'hF, `DSO_RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        `CHK("lock_ind", 1'b1, lock_ind)
        `CHK("alarm_out", 1'b1, alarm_out)
        axi_rd(`DSO_ADDR_SUPPLY, {16'h0, lvl_s & MS | 16'h0240, 2'h0});
        axi_wr(`DSO_ADDR_SUPPLY, 32'h0, 4'hF, `DSO_RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        `CHK("lock_ind", 1'b0, lock_ind)
        `CHK("alarm_out", 1'b0, alarm_out)
        // Raw levels need model, two sync flops and the output flop
        {lvl_lock, lvl_alarm} <= 2'b11;
        repeat (5) @(posedge ref_clk);
        `CHK("lock_ind", 1'b1, lock_ind)
        `CHK("alarm_out", 1'b1, alarm_out)
        $display("Test lock and alarm done");
        for (int m = 1; m >= 0; m--)
        begin
            axi_wr(`DSO_ADDR_SUPPLY, m << 8, 4'hF, `DSO_RESP_OKAY);
            repeat (3) @(posedge ref_clk);
            repeat (40)
            begin
                @(posedge ref_clk);
                tk = m ? t_16k : t_norm;
                #1 `CHK("deb_tick", tk, deb_tick)
            end
        end
        $display("Test tick force done");
        axi_wr(`DSO_ADDR_GLOBAL, 32'h1, 4'hF, `DSO_RESP_OKAY);
        axi_wr(`DSO_ADDR_REGULATOR, 32'h8F3F, 4'hF, `DSO_RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        `CHK("deb_regulator", 16'h8F3F, deb_r)
        sm_clear <= 1'b1;
        @(posedge ref_clk);
        sm_clear <= 1'b0;
        repeat (3) @(posedge ref_clk);
        `CHK("deb_regulator", 16'h0000, deb_r)
        axi_wr(`DSO_ADDR_REGULATOR, 32'hFFFF, 4'h1, `DSO_RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        `CHK("deb_regulator", 16'h003F, deb_r)
        axi_wr(12'h3FC, 32'hFFFF, 4'hF, `DSO_RESP_SLVERR);
        axi_rd(12'h3FC, {32'h0, `DSO_RESP_SLVERR});
        $display("Test clear and unmapped done");
        conclude();
    end
endmodule

/* tb/dso_src_model.sv */
`timescale 1ns/10ps
// =====================================================================
// Comparator and supervisor sources
module dso_src_model
    import dso_pkg::*;
(
    input wire logic ref_clk, // Bench clock
    input wire dso_field_t lvl_supply, // Wanted supply levels
    input wire dso_field_t lvl_regulator, // Wanted regulator levels
    input wire dso_field_t lvl_charger, // Wanted charger levels
    input wire logic lvl_lock, // Wanted lock level
    input wire logic lvl_alarm, // Wanted alarm level
    output dso_field_t raw_supply, // Supply comparator outputs
    output dso_field_t raw_regulator, // Regulator status outputs
    output dso_field_t raw_charger, // Charger comparator outputs
    output logic raw_loop_lock, // Lock flag
    output logic raw_alarm, // Alarm flag
    output logic tick_normal, // Slow tick pulse
    output logic tick_16k // Fast tick pulse
);
    logic [3:0] cnt = 4'h0;
    initial
    begin
        {raw_supply, raw_regulator, raw_charger} = 48'h0;
        {raw_loop_lock, raw_alarm, tick_normal, tick_16k} = 4'h0;
    end
    // Two tick rates that differ, so a wrong tick choice shows
    always @(posedge ref_clk)
    begin
        cnt <= cnt + 4'h1;
        raw_supply <= lvl_supply;
        raw_regulator <= lvl_regulator;
        raw_charger <= lvl_charger;
        raw_loop_lock <= lvl_lock;
        raw_alarm <= lvl_alarm;
        tick_normal <= (cnt == 4'h7);
        tick_16k <= (cnt[1:0] == 2'h1);
    end
endmodule
